// File: src/excsup_pkg.sv
/*
 Constants shared by the excitation supervision block: register map,
 field positions, reset defaults, time base and sequence states.
 Assumes a 50 MHz system clock and a 5 ms supervision tick.
*/
package excsup_pkg;
    localparam int AW = 6;
    localparam int CW = 20;
    localparam int TW = 20;

    // Register byte offsets.
    localparam logic [AW-1:0] OFF_CTRL = 6'h00;
    localparam logic [AW-1:0] OFF_OFDLY = 6'h04;
    localparam logic [AW-1:0] OFF_HI = 6'h08;
    localparam logic [AW-1:0] OFF_LO = 6'h0c;
    localparam logic [AW-1:0] OFF_TLVL = 6'h10;
    localparam logic [AW-1:0] OFF_SUP = 6'h14;
    localparam logic [AW-1:0] OFF_INV = 6'h18;
    localparam logic [AW-1:0] OFF_RATE = 6'h1c;
    localparam logic [AW-1:0] OFF_STAT = 6'h20;

    // Control and status field positions.
    localparam int CB_OF = 0;
    localparam int CB_IT = 1;
    localparam int CB_SRC = 2;
    localparam int SB_TRIP = 0;
    localparam int SB_TALM = 1;
    localparam int SB_FAIL = 2;
    localparam int SB_COND = 3;
    localparam int SB_SEQ = 4;

    localparam logic [1:0] SRC_NORMAL = 2'h0;
    localparam logic [1:0] SRC_OPEN = 2'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Reset defaults, each in its register's own step.
    localparam logic [11:0] DEF_OFDLY = 12'h258;
    localparam logic [11:0] DEF_HI = 12'h064;
    localparam logic [11:0] DEF_LO = 12'h00a;
    localparam logic [7:0] DEF_TLVL = 8'h64;
    localparam logic [14:0] DEF_SUP = 15'h0005;
    localparam logic [7:0] DEF_INV = 8'h0a;
    localparam logic [6:0] DEF_RATE = 7'h02;

    // Time base: tick in microseconds and the cycles it takes.
    localparam int TICK_US = 5000;
    localparam int CLK_MHZ = 50;
    localparam int TICK_CYCLES_DEF = TICK_US * CLK_MHZ;
    localparam int TENTH_US = 100000;
    localparam int TENTH_TICKS = TENTH_US / TICK_US;
    localparam int RAMP_TICKS = 10;
    localparam int RAMP_GAIN = RAMP_TICKS * TICK_US / 10000;
    localparam int THR_SCALE = 100;

    typedef enum logic [3:0] {
        SEQ_IDLE = 4'b0001,
        SEQ_RUNDOWN = 4'b0010,
        SEQ_TRIP = 4'b0100,
        SEQ_DONE = 4'b1000
    } seq_t;
endpackage

// File: src/excsup_timer.sv
/*
 Restartable delay timer counting supervision ticks.
 Assumes tick is a one-cycle pulse from the same clock.
*/
`timescale 1ns/100ps
module excsup_timer #(
    parameter int TW = 20
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Control.
    input wire logic run,
    input wire logic tick,
    input wire logic [TW-1:0] limit,
    // Result.
    output logic done
);
    typedef struct packed {
        logic [TW-1:0] cnt;
        logic done;
    } tst_t;

    tst_t s_r;
    tst_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (!run) begin
            s_nxt = '0;
        end else begin
            if (tick && s_r.cnt < limit) begin
                s_nxt.cnt = s_r.cnt + 1'b1;
            end
            s_nxt.done = s_r.cnt >= limit;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done = s_r.done;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_restart_zero: assert property (!run |=> s_r.cnt == '0 && !done)
        else $error("timer did not restart");
    a_done_cause: assert property ($rose(done) |->
        $past(run) && $past(s_r.cnt) >= $past(limit))
        else $error("timer expired early");
endmodule // excsup_timer

// File: src/excsup_top.sv
/*
 Excitation supervision: open-field trip, transistor temperature alarm,
 internal field-breaker trip sequence and open-loop control ramp, with
 an AXI4-Lite register slave. Assumes all inputs synchronous to aclk.
*/
// Functional notes
// - Open-field monitoring enable, off after reset
// - Condition: control high and current low
// - Condition held for delay trips rectifier
// - Open-field delay in 5 ms, default 3 s
// - High threshold in 0.01, default 1.00
// - Low threshold 0.01, default 0.10, inclusive
// - Temperature alarm at level, default 100
// - Temperature supervision cannot be disabled
// - Internal breaker trip enable, off after reset
// - Off command: run down, then open
// - Event if breaker not open in time
// - Supervision time in 0.1 s, default 0.5
// - Inverter stop time default 1.0 s
// - Open-loop option ramps control at rate
`timescale 1ns/100ps
module excsup_top
    import excsup_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF,
    parameter int TCW = 18
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels.
    input wire logic [AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels.
    input wire logic [AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Measurements, 1e-4 p.u., 0.01 p.u. and degrees.
    input wire logic [CW-1:0] ctrl_in,
    input wire logic [11:0] field_cur,
    input wire logic [7:0] igbt_temp,
    // Breaker and machine circuit.
    input wire logic mcc_open,
    input wire logic brk_off_cmd,
    input wire logic brk_open_st,
    // Open-loop ramp commands.
    input wire logic ramp_up,
    input wire logic ramp_down,
    // Outputs to the power stage and breaker.
    output logic [CW-1:0] ctrl_out,
    output logic rect_trip,
    output logic temp_alarm,
    output logic run_down,
    output logic brk_trip_cmd,
    output logic brk_fail_evt
);
    typedef struct packed {
        logic awok;
        logic [AW-1:0] awa;
        logic wok;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
        logic of_en;
        logic it_en;
        logic [1:0] src;
        logic [11:0] of_dly;
        logic [11:0] hi;
        logic [11:0] lo;
        logic [7:0] tlvl;
        logic [14:0] sup;
        logic [7:0] inv;
        logic [6:0] rate;
        logic trip;
        logic talm;
        logic fail;
        seq_t seq;
        logic [TCW-1:0] tcnt;
        logic tick;
        logic [3:0] rcnt;
        logic [CW-1:0] acc;
        logic rund;
        logic bopen;
    } st_t;

    localparam st_t ST_RST = '{of_dly: DEF_OFDLY, hi: DEF_HI, lo: DEF_LO,
        tlvl: DEF_TLVL, sup: DEF_SUP, inv: DEF_INV, rate: DEF_RATE,
        seq: SEQ_IDLE, default: '0};
    localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES - 1);
    localparam logic [3:0] RAMP_LAST = 4'(RAMP_TICKS - 1);
    localparam logic [CW-1:0] CMAX = '1;

    st_t s_r;
    st_t s_nxt;
    logic [2:0] t_run;
    logic [2:0] t_done;
    logic [TW-1:0] t_lim [3];
    logic of_cond;
    logic [CW-1:0] hi_scaled;
    logic [CW-1:0] ramp_inc;

    // Byte-lane merge of a register's old value with write data.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Word-aligned register byte offset of a byte address.
    function automatic logic [AW-1:0] align(input logic [AW-1:0] a);
        return {a[AW-1:2], 2'b00};
    endfunction

    assign hi_scaled = CW'(s_r.hi * THR_SCALE);
    assign ramp_inc = CW'(s_r.rate * RAMP_GAIN);
    // Inclusive low-current test; the control side must exceed.
    assign of_cond = s_r.of_en && s_r.acc > hi_scaled
        && field_cur <= s_r.lo;

    assign t_run[0] = of_cond;
    assign t_lim[0] = TW'(s_r.of_dly);
    assign t_run[1] = s_r.seq == SEQ_RUNDOWN;
    assign t_lim[1] = TW'(s_r.inv * TENTH_TICKS);
    assign t_run[2] = s_r.seq == SEQ_TRIP;
    assign t_lim[2] = TW'(s_r.sup * TENTH_TICKS);

    generate
        for (genvar g = 0; g < 3; g++) begin : g_tmr
            excsup_timer #(.TW(TW)) u_tmr (
                .aclk(aclk),
                .aresetn(aresetn),
                .run(t_run[g]),
                .tick(s_r.tick),
                .limit(t_lim[g]),
                .done(t_done[g])
            );
        end
    endgenerate

    always_comb begin
        logic [31:0] w;
        logic [AW-1:0] ra;
        logic clr_trip;
        logic clr_fail;
        logic fail_set;
        logic [CW:0] sum;
        w = '0;
        ra = align(araddr);
        clr_trip = 1'b0;
        clr_fail = 1'b0;
        fail_set = 1'b0;
        sum = '0;
        s_nxt = s_r;

        // Supervision tick from the system clock.
        s_nxt.tick = 1'b0;
        if (s_r.tcnt == TICK_LAST) begin
            s_nxt.tcnt = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.tcnt = s_r.tcnt + 1'b1;
        end

        // Write address and data are taken independently.
        if (awvalid && awready) begin
            s_nxt.awok = 1'b1;
            s_nxt.awa = align(awaddr);
        end
        if (wvalid && wready) begin
            s_nxt.wok = 1'b1;
            s_nxt.wd = wdata;
            s_nxt.ws = wstrb;
        end
        if (s_r.bv && bready) begin
            s_nxt.bv = 1'b0;
        end
        if (s_r.awok && s_r.wok && !s_r.bv) begin
            s_nxt.awok = 1'b0;
            s_nxt.wok = 1'b0;
            s_nxt.bv = 1'b1;
            s_nxt.br = RESP_OKAY;
            case (s_r.awa)
                OFF_CTRL: begin
                    w = merge({28'h0, s_r.src, s_r.it_en, s_r.of_en},
                              s_r.wd, s_r.ws);
                    s_nxt.of_en = w[CB_OF];
                    s_nxt.it_en = w[CB_IT];
                    s_nxt.src = w[CB_SRC +: 2];
                end
                OFF_OFDLY: begin
                    w = merge({20'h0, s_r.of_dly}, s_r.wd, s_r.ws);
                    s_nxt.of_dly = w[11:0];
                end
                OFF_HI: begin
                    w = merge({20'h0, s_r.hi}, s_r.wd, s_r.ws);
                    s_nxt.hi = w[11:0];
                end
                OFF_LO: begin
                    w = merge({20'h0, s_r.lo}, s_r.wd, s_r.ws);
                    s_nxt.lo = w[11:0];
                end
                OFF_TLVL: begin
                    w = merge({24'h0, s_r.tlvl}, s_r.wd, s_r.ws);
                    s_nxt.tlvl = w[7:0];
                end
                OFF_SUP: begin
                    w = merge({17'h0, s_r.sup}, s_r.wd, s_r.ws);
                    s_nxt.sup = w[14:0];
                end
                OFF_INV: begin
                    w = merge({24'h0, s_r.inv}, s_r.wd, s_r.ws);
                    s_nxt.inv = w[7:0];
                end
                OFF_RATE: begin
                    w = merge({25'h0, s_r.rate}, s_r.wd, s_r.ws);
                    s_nxt.rate = w[6:0];
                end
                OFF_STAT: begin
                    w = s_r.wd & {32{s_r.ws[0]}};
                    clr_trip = w[SB_TRIP];
                    clr_fail = w[SB_FAIL];
                end
                default: begin
                    s_nxt.br = RESP_DECERR;
                end
            endcase
        end

        // Read channel.
        if (s_r.rv && rready) begin
            s_nxt.rv = 1'b0;
        end
        if (arvalid && arready) begin
            s_nxt.rv = 1'b1;
            s_nxt.rr = RESP_OKAY;
            case (ra)
                OFF_CTRL: s_nxt.rd = {28'h0, s_r.src, s_r.it_en, s_r.of_en};
                OFF_OFDLY: s_nxt.rd = {20'h0, s_r.of_dly};
                OFF_HI: s_nxt.rd = {20'h0, s_r.hi};
                OFF_LO: s_nxt.rd = {20'h0, s_r.lo};
                OFF_TLVL: s_nxt.rd = {24'h0, s_r.tlvl};
                OFF_SUP: s_nxt.rd = {17'h0, s_r.sup};
                OFF_INV: s_nxt.rd = {24'h0, s_r.inv};
                OFF_RATE: s_nxt.rd = {25'h0, s_r.rate};
                OFF_STAT: s_nxt.rd = {24'h0, s_r.seq, of_cond, s_r.fail,
                                      s_r.talm, s_r.trip};
                default: begin
                    s_nxt.rd = '0;
                    s_nxt.rr = RESP_DECERR;
                end
            endcase
        end

        // Open-field trip latches; a new expiry beats a clear.
        if (t_done[0]) begin
            s_nxt.trip = 1'b1;
        end else if (clr_trip) begin
            s_nxt.trip = 1'b0;
        end

        // No enable exists for this comparison on purpose.
        s_nxt.talm = igbt_temp >= s_r.tlvl;

        case (s_r.seq)
            SEQ_IDLE: begin
                if (s_r.it_en && mcc_open && brk_off_cmd) begin
                    s_nxt.seq = SEQ_RUNDOWN;
                end
            end
            SEQ_RUNDOWN: begin
                if (t_done[1]) begin
                    s_nxt.seq = SEQ_TRIP;
                end
            end
            SEQ_TRIP: begin
                if (brk_open_st) begin
                    s_nxt.seq = SEQ_DONE;
                end else if (t_done[2]) begin
                    s_nxt.seq = SEQ_DONE;
                    fail_set = 1'b1;
                end
            end
            SEQ_DONE: begin
                if (!brk_off_cmd) begin
                    s_nxt.seq = SEQ_IDLE;
                end
            end
            default: begin
                s_nxt.seq = SEQ_IDLE;
            end
        endcase
        if (!s_r.it_en) begin
            s_nxt.seq = SEQ_IDLE;
        end
        s_nxt.rund = s_nxt.seq != SEQ_IDLE;
        s_nxt.bopen = s_nxt.seq == SEQ_TRIP || s_nxt.seq == SEQ_DONE;

        if (fail_set) begin
            s_nxt.fail = 1'b1;
        end else if (clr_fail) begin
            s_nxt.fail = 1'b0;
        end

        // Outside open loop the ramp tracks the input, so entry is bumpless.
        if (s_r.src == SRC_OPEN) begin
            if (s_r.tick) begin
                s_nxt.rcnt = s_r.rcnt + 1'b1;
                if (s_r.rcnt == RAMP_LAST) begin
                    s_nxt.rcnt = '0;
                    if (ramp_up && !ramp_down) begin
                        sum = {1'b0, s_r.acc} + {1'b0, ramp_inc};
                        s_nxt.acc = sum[CW] ? CMAX : sum[CW-1:0];
                    end else if (ramp_down && !ramp_up) begin
                        s_nxt.acc = s_r.acc > ramp_inc ?
                            s_r.acc - ramp_inc : '0;
                    end
                end
            end
        end else begin
            s_nxt.rcnt = '0;
            s_nxt.acc = ctrl_in;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= ST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign awready = !s_r.awok && !s_r.bv;
    assign wready = !s_r.wok && !s_r.bv;
    assign bvalid = s_r.bv;
    assign bresp = s_r.br;
    assign arready = !s_r.rv;
    assign rvalid = s_r.rv;
    assign rdata = s_r.rd;
    assign rresp = s_r.rr;
    assign ctrl_out = s_r.acc;
    assign rect_trip = s_r.trip;
    assign temp_alarm = s_r.talm;
    assign run_down = s_r.rund;
    assign brk_trip_cmd = s_r.bopen;
    assign brk_fail_evt = s_r.fail;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_rundown;
        s_r.seq == SEQ_RUNDOWN && !brk_trip_cmd;
    endsequence
    sequence s_open_cmd;
        s_r.seq == SEQ_TRIP && brk_trip_cmd && run_down;
    endsequence

    a_of_enable: assert property (!s_r.of_en |-> !of_cond)
        else $error("open-field detection while disabled");
    a_of_cond: assert property ($rose(rect_trip) |-> $past(s_r.of_en &&
        ctrl_out > CW'(s_r.hi * THR_SCALE) && field_cur <= s_r.lo, 2))
        else $error("open-field condition mismatched");
    a_trip_cause: assert property ($rose(rect_trip) |->
        $past(t_done[0]) && $past(t_run[0], 2))
        else $error("trip without expired delay");
    a_rst_defaults: assert property ($rose(aresetn) |-> s_r.of_dly ==
        DEF_OFDLY && s_r.hi == DEF_HI && s_r.lo == DEF_LO)
        else $error("open-field defaults wrong");
    a_temp_alarm: assert property (igbt_temp >= s_r.tlvl |=>
        temp_alarm)
        else $error("temperature alarm missing");
    a_temp_clear: assert property (igbt_temp < s_r.tlvl |=>
        !temp_alarm)
        else $error("temperature alarm without cause");
    a_it_disabled: assert property (!s_r.it_en |=>
        s_r.seq == SEQ_IDLE && !run_down)
        else $error("breaker sequence while disabled");
    a_rundown_open: assert property (s_rundown ##1 s_r.seq == SEQ_TRIP
        |-> s_open_cmd)
        else $error("breaker open out of order");
    a_open_first: assert property ($rose(brk_trip_cmd) |->
        $past(s_r.seq == SEQ_RUNDOWN) && $past(t_done[1]))
        else $error("breaker opened before run down");
    a_brk_event: assert property ($rose(brk_fail_evt) |->
        $past(s_r.seq == SEQ_TRIP && !brk_open_st && t_done[2]))
        else $error("breaker event without timeout");
    a_sup_limit: assert property (t_lim[2] * TICK_US ==
        s_r.sup * TENTH_US)
        else $error("supervision limit wrong");
    a_ramp_step: assert property (s_r.src == SRC_OPEN && s_r.tick &&
        s_r.rcnt == RAMP_LAST && ramp_up && !ramp_down &&
        s_r.acc < CMAX - ramp_inc |=>
        ctrl_out == $past(s_r.acc) + $past(ramp_inc))
        else $error("ramp step wrong");
endmodule // excsup_top

// File: test/brk_model.sv
/*
 Field breaker model: reports open a set number of cycles after the trip
 command, or never while stuck is high.
 Assumes the clock of the block under test.
*/
`timescale 1ns/100ps
module brk_model #(
    parameter int OPEN_DLY = 10
) (
    // Clock.
    input wire logic aclk,
    // Coil and status.
    input wire logic trip,
    input wire logic stuck,
    output logic open_st
);
    int cnt = 0;
    initial open_st = 1'h0;
    // A reclosed breaker drops its open status once the coil releases.
    always @(posedge aclk) begin
        if (!trip) begin
            cnt <= 0;
            open_st <= 1'h0;
        end else if (!stuck && cnt == OPEN_DLY) begin
            open_st <= 1'h1;
        end else if (!stuck) begin
            cnt <= cnt + 1;
        end
    end
endmodule // brk_model

// File: test/tb_top.sv
/*
 Self-checking bench for the excitation supervision block.
 Assumes a short tick of four cycles and the breaker model beside it.
*/
`timescale 1ns/100ps
module tb_top;
    import excsup_pkg::*;
    localparam int T = 4;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [AW-1:0] awaddr = 6'h0, araddr = 6'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic [CW-1:0] ctrl_in = 20'h0;
    logic [11:0] field_cur = 12'h0;
    logic [7:0] igbt_temp = 8'h0;
    logic mcc_open = 1'h0, brk_off_cmd = 1'h0, stuck = 1'h0;
    logic ramp_up = 1'h0, ramp_down = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, brk_open_st;
    logic rect_trip, temp_alarm, run_down, brk_trip_cmd, brk_fail_evt;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rv;
    logic [CW-1:0] ctrl_out;
    logic [15:0] seed = 16'h005f;
    int mismatches = 0, checked = 0, cycles = 0;
    int mdl [9] = '{32'h0, 32'h258, 32'h64, 32'ha, 32'h64, 32'h5, 32'ha,
        32'h2, 32'h0};
    int msk [9] = '{32'hf, 32'hfff, 32'hfff, 32'hfff, 32'hff, 32'h7fff,
        32'hff, 32'h7f, 32'hff};

    excsup_top #(.TICK_CYCLES(T)) u_excsup_top (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .ctrl_in(ctrl_in), .field_cur(field_cur), .igbt_temp(igbt_temp),
        .mcc_open(mcc_open), .brk_off_cmd(brk_off_cmd),
        .brk_open_st(brk_open_st), .ramp_up(ramp_up),
        .ramp_down(ramp_down), .ctrl_out(ctrl_out),
        .rect_trip(rect_trip), .temp_alarm(temp_alarm),
        .run_down(run_down), .brk_trip_cmd(brk_trip_cmd),
        .brk_fail_evt(brk_fail_evt));
    brk_model u_brk_model (.aclk(aclk), .trip(brk_trip_cmd),
        .stuck(stuck), .open_st(brk_open_st));

    always #10 aclk = ~aclk;

    task stop_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            stop_test;
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time,
                what, got, exp);
        end
    endtask

    // Each channel is released on the edge that takes it, not before.
    task wr(input logic [AW-1:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'h0;
            if (wvalid && wready)
                wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        rs = bresp;
        bready <= 1'h0;
    endtask

    task rd(input logic [AW-1:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rv = rdata;
        rs = rresp;
        rready <= 1'h0;
    endtask

    task set(input int i, input logic [31:0] v);
        wr(AW'(i * 4), v);
        mdl[i] = v & msk[i];
        chk(rs, RESP_OKAY, "bresp");
    endtask

    task get(input int i);
        rd(AW'(i * 4));
        chk(rv, 32'(mdl[i]), "reg");
        chk(rs, RESP_OKAY, "rresp");
    endtask

    initial begin
        cyc(6);
        aresetn <= 1'h1;
        for (int i = 0; i < 8; i++)
            get(i);
        rd(6'h24);
        chk(rv, 32'h0, "unmapped data");
        chk(rs, RESP_DECERR, "unmapped rresp");
        wr(6'h24, 32'hffff);
        chk(rs, RESP_DECERR, "unmapped bresp");
        igbt_temp <= 8'h63;
        cyc(3);
        chk(temp_alarm, 1'h0, "alarm below");
        igbt_temp <= 8'h64;
        cyc(3);
        chk(temp_alarm, 1'h1, "alarm at level");
        rd(OFF_STAT);
        chk(rv[SB_TALM], 1'h1, "alarm status");
        igbt_temp <= 8'h14;
        for (int i = 1; i < 8; i++) begin
            seed = lfsr(seed);
            set(i, {16'h0, seed});
            get(i);
        end
        wstrb <= 4'h1;
        wr(OFF_HI, 32'hfff);
        mdl[2] = (mdl[2] & 32'hf00) | 32'hff;
        wstrb <= 4'hf;
        get(2);
        set(1, 32'h5);
        set(2, 32'h64);
        set(3, 32'ha);
        set(0, 32'h0);
        ctrl_in <= 20'h02711;
        field_cur <= 12'h00a;
        cyc(60);
        chk(rect_trip, 1'h0, "trip disabled");
        rd(OFF_STAT);
        chk(rv[SB_COND], 1'h0, "cond disabled");
        field_cur <= 12'h00b;
        set(0, 32'h1);
        cyc(60);
        chk(rect_trip, 1'h0, "current above low");
        ctrl_in <= 20'h02710;
        field_cur <= 12'h00a;
        cyc(60);
        chk(rect_trip, 1'h0, "control at high");
        ctrl_in <= 20'h02711;
        cyc(14);
        field_cur <= 12'h00b;
        cyc(2);
        field_cur <= 12'h00a;
        cyc(14);
        chk(rect_trip, 1'h0, "restart");
        cyc(16);
        chk(rect_trip, 1'h1, "trip");
        field_cur <= 12'h00b;
        set(8, 32'h1);
        cyc(2);
        chk(rect_trip, 1'h0, "trip clear");
        ctrl_in <= 20'h01388;
        cyc(3);
        chk(ctrl_out, 20'h01388, "pass through");
        set(7, 32'h2);
        ramp_up <= 1'h1;
        // The open-loop source is only selected in this test phase.
        set(0, 32'h4);
        cyc(400);
        chk(ctrl_out >= 20'h013e2 && ctrl_out <= 20'h013f6, 1'h1,
            "ramp up");
        ramp_up <= 1'h0;
        ramp_down <= 1'h1;
        set(7, 32'h7f);
        cyc(400);
        chk(ctrl_out, 20'h0, "ramp floor");
        ramp_down <= 1'h0;
        set(0, 32'h0);
        cyc(3);
        chk(ctrl_out, 20'h01388, "normal again");
        set(5, 32'h1);
        set(6, 32'h1);
        mcc_open <= 1'h1;
        brk_off_cmd <= 1'h1;
        cyc(20);
        chk(run_down, 1'h0, "trip disabled");
        brk_off_cmd <= 1'h0;
        set(0, 32'h2);
        mcc_open <= 1'h0;
        brk_off_cmd <= 1'h1;
        cyc(20);
        chk(run_down, 1'h0, "circuit closed");
        brk_off_cmd <= 1'h0;
        cyc(2);
        mcc_open <= 1'h1;
        brk_off_cmd <= 1'h1;
        cyc(3);
        chk(run_down, 1'h1, "run down");
        cyc(60);
        chk(brk_trip_cmd, 1'h0, "open early");
        cyc(30);
        chk(brk_trip_cmd, 1'h1, "open");
        cyc(100);
        chk(brk_fail_evt, 1'h0, "no event");
        brk_off_cmd <= 1'h0;
        stuck <= 1'h1;
        cyc(3);
        brk_off_cmd <= 1'h1;
        cyc(93);
        chk(brk_trip_cmd, 1'h1, "open stuck");
        cyc(60);
        chk(brk_fail_evt, 1'h0, "event early");
        cyc(30);
        chk(brk_fail_evt, 1'h1, "event");
        set(8, 32'h4);
        cyc(2);
        chk(brk_fail_evt, 1'h0, "event clear");
        stop_test;
    end
endmodule // tb_top
